// ### core/vpg_top.sv
// Voice-path equalisers, gain stages, mode registers and Avalon-MM slave
//
// Chosen here: register access over Avalon-MM.
`timescale 1ns/10ps
module vpg_top
  import vpg_pkg::*;
#(
  parameter int SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
)
(
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_AVM_ADDRESS,
  input wire logic I_AVM_READ,
  input wire logic I_AVM_WRITE,
  input wire logic [31:0] I_AVM_WRITEDATA,
  input wire logic [3:0] I_AVM_BYTEENABLE,
  output logic [31:0] O_AVM_READDATA,
  output logic O_AVM_WAITREQUEST,
  input wire logic [SMP_W-1:0] I_ADC_SAMPLE,
  input wire logic [SMP_W-1:0] I_RX_PCM,
  output logic [SMP_W-1:0] O_TX_SAMPLE,
  output logic [SMP_W-1:0] O_RX_SAMPLE,
  output logic O_SAMPLE_VALID,
  output logic O_ALAW_SEL,
  output logic O_ANALOG_DISABLE,
  output logic O_INPUT_MUTE,
  output logic [2:0] O_PREAMP_GAIN
);
  localparam int CNT_W = $clog2(SAMPLE_CYCLES);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SAMPLE_CYCLES - 1);
  localparam logic signed [ACC_W-1:0] ACC_MAX = ACC_W'(32767 <<< FRAC_W);
  localparam logic signed [ACC_W-1:0] ACC_MIN = -ACC_W'(32768 <<< FRAC_W);
  logic [7:0] shadow_ff [NUM_BYTES];
  logic [7:0] active_ff [NUM_BYTES];
  logic [7:0] mode1_ff, mode2_ff, mode3_ff, ringa_ff, ringf_ff;
  logic [7:0] peaktx_ff, peakrx_ff;
  logic [7:0] last_idx_ff;
  logic [3:0] ptr_ff;
  logic ack_ff;
  logic [31:0] rdata_ff;
  logic [CNT_W-1:0] cnt_ff;
  logic strobe;
  logic [SMP_W-1:0] tx_hist_ff [NUM_TAPS-1];
  logic [SMP_W-1:0] rx_hist_ff [NUM_TAPS-1];
  logic [SMP_W-1:0] tx_ff, rx_ff;
  logic valid_ff;
  // Signed power-of-two factor
  function automatic logic signed [ACC_W-1:0] fac(input logic s,
    input logic [2:0] m, input logic signed [ACC_W-1:0] v);
    logic signed [ACC_W-1:0] t;
    t = v >>> m;
    return s ? -t : t;
  endfunction
  function automatic logic signed [ACC_W-1:0] tap_mul(input logic [15:0] c,
    input logic signed [ACC_W-1:0] x);
    logic signed [ACC_W-1:0] t;
    t = x + fac(c[3], c[2:0], x);
    t = x + fac(c[7], c[6:4], t);
    t = x + fac(c[11], c[10:8], t);
    return fac(c[15], c[14:12], t);
  endfunction
  function automatic logic signed [ACC_W-1:0] ext(input logic [SMP_W-1:0] s);
    return ACC_W'(signed'(s)) <<< FRAC_W;
  endfunction
  function automatic logic [SMP_W-1:0] sat(input logic signed [ACC_W-1:0] a);
    logic signed [ACC_W-1:0] c;
    c = (a > ACC_MAX) ? ACC_MAX : ((a < ACC_MIN) ? ACC_MIN : a);
    return c[SMP_W+FRAC_W-1:FRAC_W];
  endfunction
  function automatic logic [15:0] coef_at(input int b);
    return {active_ff[b+1], active_ff[b]};
  endfunction
  function automatic logic [4:0] reg_len(input logic [7:0] idx);
    case (idx)
      IDX_XFILT, IDX_RFILT: return 5'(LEN_FILT);
      IDX_TXGAIN, IDX_RXGAIN, IDX_STGAIN, IDX_TONEF, IDX_TONEA,
      IDX_ERGAIN: return 5'(LEN_PAIR);
      default: return 5'h00;
    endcase
  endfunction
  function automatic int reg_base(input logic [7:0] idx);
    case (idx)
      IDX_XFILT: return BASE_X;
      IDX_RFILT: return BASE_R;
      IDX_TXGAIN: return BASE_TXG;
      IDX_RXGAIN: return BASE_RXG;
      IDX_STGAIN: return BASE_STG;
      IDX_TONEF: return BASE_TONEF;
      IDX_TONEA: return BASE_TONEA;
      default: return BASE_ERG;
    endcase
  endfunction
  function automatic logic [7:0] abs_hi(input logic [SMP_W-1:0] s);
    logic [SMP_W-1:0] a;
    a = s[SMP_W-1] ? SMP_W'(~s + 1'b1) : s;
    return a[SMP_W-1:SMP_W-8];
  endfunction
  // Bus request decode
  logic req, take, wr_ok, multi, last_byte;
  logic [3:0] eff_ptr;
  logic [4:0] len;
  int base;
  assign req = I_AVM_READ | I_AVM_WRITE;
  assign take = req & ack_ff;
  assign wr_ok = take & I_AVM_WRITE & I_AVM_BYTEENABLE[0];
  assign len = reg_len(I_AVM_ADDRESS);
  assign multi = (len != 5'h00);
  assign base = reg_base(I_AVM_ADDRESS);
  assign eff_ptr = (I_AVM_ADDRESS == last_idx_ff) ? ptr_ff : 4'h0;
  assign last_byte = ({1'b0, eff_ptr} == len - 5'h01);
  assign O_AVM_WAITREQUEST = req & ~ack_ff;
  assign O_AVM_READDATA = rdata_ff;

  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end
  // Byte pointer walks a multi-byte register
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      ptr_ff <= 4'h0;
      last_idx_ff <= 8'h00;
    end
    else if (take)
    begin
      last_idx_ff <= I_AVM_ADDRESS;
      ptr_ff <= (multi && !last_byte) ? eff_ptr + 4'h1 : 4'h0;
    end
  end
  logic [7:0] rd_byte;
  always_comb
  begin
    rd_byte = 8'h00;
    if (multi)
      rd_byte = shadow_ff[base + int'(eff_ptr)];
    else
      case (I_AVM_ADDRESS)
        IDX_MODE1: rd_byte = mode1_ff;
        IDX_MODE2: rd_byte = mode2_ff;
        IDX_MODE3: rd_byte = mode3_ff;
        IDX_RINGA: rd_byte = ringa_ff;
        IDX_RINGF: rd_byte = ringf_ff;
        IDX_PEAKTX: rd_byte = peaktx_ff;
        IDX_PEAKRX: rd_byte = peakrx_ff;
        default: rd_byte = 8'h00;
      endcase
  end
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
      rdata_ff <= 32'h0000_0000;
    else if (I_AVM_READ & ~ack_ff)
      rdata_ff <= {24'h00_0000, rd_byte};
  end
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      for (int k = BASE_TONEF; k < BASE_TONEF + LEN_PAIR; k++)
      begin
        shadow_ff[k] <= 8'h00;
        active_ff[k] <= 8'h00;
      end
    end
    else if (wr_ok && multi)
    begin
      shadow_ff[base + int'(eff_ptr)] <= I_AVM_WRITEDATA[7:0];
      if (last_byte)
        for (int k = 0; k < NUM_BYTES; k++)
          if (k >= base && k < base + int'(len))
            active_ff[k] <= (k == base + int'(eff_ptr)) ?
              I_AVM_WRITEDATA[7:0] : shadow_ff[k];
    end
  end
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      mode1_ff <= MODE_RESET;
      mode2_ff <= MODE_RESET;
      mode3_ff <= MODE_RESET;
      ringa_ff <= MODE_RESET;
      ringf_ff <= MODE_RESET;
    end
    else if (wr_ok)
      case (I_AVM_ADDRESS)
        // mode register one at its index
        IDX_MODE1: mode1_ff <= I_AVM_WRITEDATA[7:0];
        IDX_MODE2: mode2_ff <= I_AVM_WRITEDATA[7:0] & RSVD_TOP_MASK;
        IDX_MODE3: mode3_ff <= I_AVM_WRITEDATA[7:0] & RSVD_TOP_MASK;
        IDX_RINGA: ringa_ff <= I_AVM_WRITEDATA[7:0];
        IDX_RINGF: ringf_ff <= I_AVM_WRITEDATA[7:0];
        default: ;
      endcase
  end
  assign strobe = (cnt_ff == CNT_LAST);
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST || strobe)
      cnt_ff <= '0;
    else
      cnt_ff <= cnt_ff + 1'b1;
  end
  // Sample datapath
  logic [SMP_W-1:0] rx_g, rx_ge, rx_f, rx_out, tx_src, tx_f, tx_g;
  logic signed [ACC_W-1:0] acc_tx, acc_rx, st, lb;
  logic [15:0] cg;
  always_comb
  begin
    cg = coef_at(BASE_RXG);
    rx_g = I_RX_PCM;
    if (mode1_ff[M1_RXG])
      rx_g = (cg == COEF_MUTE_MAIN) ? '0 : sat(tap_mul(cg, ext(I_RX_PCM)));
    cg = coef_at(BASE_ERG);
    rx_ge = rx_g;
    if (mode1_ff[M1_ERG])
      rx_ge = (cg == COEF_MUTE_EXTRA) ? '0 : sat(tap_mul(cg, ext(rx_g)));
    // eight-tap sums over current and past samples
    acc_rx = tap_mul(coef_at(BASE_R), ext(rx_ge));
    for (int j = 1; j < NUM_TAPS; j++)
      acc_rx = acc_rx + tap_mul(coef_at(BASE_R + 2 * j), ext(rx_hist_ff[j-1]));
    rx_f = mode1_ff[M1_RF] ? sat(acc_rx) : rx_ge;
    cg = coef_at(BASE_STG);
    if (!mode1_ff[M1_STG])
      st = ext(tx_ff) >>> ST_FIXED_SHIFT;
    else if (cg == COEF_MUTE_MAIN)
      st = '0;
    else
      st = tap_mul(cg, ext(tx_ff));
    rx_out = sat(ext(rx_f) + st);
    lb = ext(rx_ff) + (ext(rx_ff) >>> 2) + (ext(rx_ff) >>> 4)
      + (ext(rx_ff) >>> 6);
    if (mode1_ff[M1_LOOP1])
      tx_src = sat(lb);
    // loopback two routes output path back
    else if (mode3_ff[M3_LOOP2])
      tx_src = rx_ff;
    else
      tx_src = I_ADC_SAMPLE;
    acc_tx = tap_mul(coef_at(BASE_X), ext(tx_src));
    for (int j = 1; j < NUM_TAPS; j++)
      acc_tx = acc_tx + tap_mul(coef_at(BASE_X + 2 * j), ext(tx_hist_ff[j-1]));
    tx_f = mode1_ff[M1_XF] ? sat(acc_tx) : tx_src;
    cg = coef_at(BASE_TXG);
    tx_g = tx_f;
    if (mode1_ff[M1_TXG])
      tx_g = (cg == COEF_MUTE_MAIN) ? '0 : sat(tap_mul(cg, ext(tx_f)));
  end
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      tx_ff <= '0;
      rx_ff <= '0;
      valid_ff <= 1'b0;
      for (int j = 0; j < NUM_TAPS - 1; j++)
      begin
        tx_hist_ff[j] <= '0;
        rx_hist_ff[j] <= '0;
      end
    end
    else
    begin
      valid_ff <= strobe;
      if (strobe)
      begin
        tx_ff <= tx_g;
        rx_ff <= rx_out;
        tx_hist_ff[0] <= tx_src;
        rx_hist_ff[0] <= rx_ge;
        for (int j = 1; j < NUM_TAPS - 1; j++)
        begin
          tx_hist_ff[j] <= tx_hist_ff[j-1];
          rx_hist_ff[j] <= rx_hist_ff[j-1];
        end
      end
    end
  end
  // Peak hold, cleared by read; a sample taken in the read cycle is loaded, peak or not
  logic peak_rd_tx, peak_rd_rx;
  assign peak_rd_tx = take & I_AVM_READ & (I_AVM_ADDRESS == IDX_PEAKTX);
  assign peak_rd_rx = take & I_AVM_READ & (I_AVM_ADDRESS == IDX_PEAKRX);
  always_ff @(posedge I_REF_CLK)
  begin
    if (I_RST)
    begin
      peaktx_ff <= 8'h00;
      peakrx_ff <= 8'h00;
    end
    else
    begin
      if (strobe && (abs_hi(tx_g) > peaktx_ff || peak_rd_tx))
        peaktx_ff <= abs_hi(tx_g);
      else if (peak_rd_tx)
        peaktx_ff <= 8'h00;
      if (strobe && (abs_hi(rx_out) > peakrx_ff || peak_rd_rx))
        peakrx_ff <= abs_hi(rx_out);
      else if (peak_rd_rx)
        peakrx_ff <= 8'h00;
    end
  end
  assign O_TX_SAMPLE = tx_ff;
  assign O_RX_SAMPLE = rx_ff;
  assign O_SAMPLE_VALID = valid_ff;
  assign O_ALAW_SEL = mode1_ff[M1_ALAW];
  assign O_ANALOG_DISABLE = mode3_ff[M3_LOOP2];
  assign O_INPUT_MUTE = mode3_ff[M3_MUTE] | mode3_ff[M3_LOOP2];
  // preamp code limited to its range
  assign O_PREAMP_GAIN = (mode3_ff[M3_GAIN_LSB+2:M3_GAIN_LSB] > PREAMP_MAX) ?
    PREAMP_MAX : mode3_ff[M3_GAIN_LSB+2:M3_GAIN_LSB];
endmodule

// ### core/vpg_pkg.sv
// Constants for the voice-path gain and filter block
// Function
// - Each equaliser is an eight-tap FIR run once per 0.125 ms sample.
// - A tap is A3*(1+A2*(1+A1*(1+A0))), each Ai a signed power of two.
// - Low byte holds S1,M1,S0,M0; high byte holds S3,M3,S2,M2.
// - Filter bytes load in order h0 low, h0 high, through h7 high.
// - Register set: two 16-byte filters, six 2-byte and seven 1-byte registers.
// - Reset clears tone frequency, mode, ringer and peak registers; others keep contents.
// - Disabled or after reset: flat filters, 0 dB gains, sidetone at -18 dB.
// - Mode register one sits at 69H; bit 0 selects A-law, else mu-law.
// - Mode bits 1-3 enable transmit, receive, extra receive gains, else 0 dB.
// - Mode bits 4-5 enable transmit and receive equalisers, else flat.
// - Mode bit 6 applies programmed sidetone gain, else fixed -18 dB.
// - Mode bit 7 loops interpolator output into decimator, about 2.5 dB gain.
// - Loopback two routes D/A to A/D unless mode bit 7 is set, and disables analog outputs and inputs.
// - Guaranteed gain ranges in 0.5 dB steps plus infinite attenuation.
// - Design gain ranges reach further in about 0.1 dB steps.
// - Preamp and analog sidetone gains stay within their own stated ranges.
// - Code 9008 hex silences enabled transmit, receive and sidetone gains.
// - Code 0008 hex silences the enabled extra receive gain.
// - Mode register three bit 2 enables digital loopback two.
package vpg_pkg;
  localparam int SMP_W = 16;
  localparam int FRAC_W = 8;
  localparam int ACC_W = 32;
  localparam int NUM_TAPS = 8;
  localparam int SAMPLE_PERIOD_NS = 125000;
  localparam int CLK_PERIOD_NS = 25;
  localparam int SAMPLE_CYCLES_DEF = SAMPLE_PERIOD_NS / CLK_PERIOD_NS;
  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_XFILT = 8'h61;
  localparam logic [7:0] IDX_RFILT = 8'h62;
  localparam logic [7:0] IDX_TXGAIN = 8'h63;
  localparam logic [7:0] IDX_RXGAIN = 8'h64;
  localparam logic [7:0] IDX_STGAIN = 8'h65;
  localparam logic [7:0] IDX_TONEF = 8'h66;
  localparam logic [7:0] IDX_TONEA = 8'h67;
  localparam logic [7:0] IDX_ERGAIN = 8'h68;
  localparam logic [7:0] IDX_MODE1 = 8'h69;
  localparam logic [7:0] IDX_MODE2 = 8'h6A;
  localparam logic [7:0] IDX_MODE3 = 8'h6C;
  localparam logic [7:0] IDX_RINGA = 8'h6D;
  localparam logic [7:0] IDX_RINGF = 8'h6E;
  localparam logic [7:0] IDX_PEAKTX = 8'h70;
  localparam logic [7:0] IDX_PEAKRX = 8'h71;
  // Byte positions in the coefficient store
  localparam int NUM_BYTES = 44;
  localparam int BASE_X = 0;
  localparam int BASE_R = 16;
  localparam int BASE_TXG = 32;
  localparam int BASE_RXG = 34;
  localparam int BASE_STG = 36;
  localparam int BASE_TONEF = 38;
  localparam int BASE_TONEA = 40;
  localparam int BASE_ERG = 42;
  localparam int LEN_FILT = 16;
  localparam int LEN_PAIR = 2;
  // Mode register fields
  localparam int M1_ALAW = 0;
  localparam int M1_TXG = 1;
  localparam int M1_RXG = 2;
  localparam int M1_ERG = 3;
  localparam int M1_XF = 4;
  localparam int M1_RF = 5;
  localparam int M1_STG = 6;
  localparam int M1_LOOP1 = 7;
  localparam int M3_LOOP2 = 2;
  localparam int M3_MUTE = 3;
  localparam int M3_GAIN_LSB = 4;
  localparam logic [7:0] RSVD_TOP_MASK = 8'h7F;
  localparam logic [2:0] PREAMP_MAX = 3'h4;
  localparam logic [7:0] MODE_RESET = 8'h00;
  localparam logic [15:0] COEF_MUTE_MAIN = 16'h9008;
  localparam logic [15:0] COEF_MUTE_EXTRA = 16'h0008;
  localparam logic [2:0] ST_FIXED_SHIFT = 3'h3;
endpackage

// ### testbench/vpg_chk.sv
// Port assertions for the voice-path block
`timescale 1ns/10ps
module vpg_chk
  import vpg_pkg::*;
#(
  parameter int SAMPLE_CYCLES = 8
)
(
  input wire logic I_REF_CLK,
  input wire logic I_RST,
  input wire logic [7:0] I_AVM_ADDRESS,
  input wire logic I_AVM_READ,
  input wire logic I_AVM_WRITE,
  input wire logic [31:0] I_AVM_WRITEDATA,
  input wire logic [3:0] I_AVM_BYTEENABLE,
  input wire logic [31:0] O_AVM_READDATA,
  input wire logic O_AVM_WAITREQUEST,
  input wire logic [SMP_W-1:0] O_TX_SAMPLE,
  input wire logic O_SAMPLE_VALID,
  input wire logic O_ALAW_SEL,
  input wire logic O_ANALOG_DISABLE,
  input wire logic O_INPUT_MUTE,
  input wire logic [2:0] O_PREAMP_GAIN
);
  default clocking cb @(posedge I_REF_CLK);
  endclocking
  default disable iff (I_RST);
  logic rq;
  logic wt;
  int gap_ff;
  logic seen_ff;
  assign rq = I_AVM_READ || I_AVM_WRITE;
  assign wt = I_AVM_WRITE && !O_AVM_WAITREQUEST && I_AVM_BYTEENABLE[0];
  // Cycles since the last sample pulse
  always_ff @(posedge I_REF_CLK)
  begin
    gap_ff <= (I_RST || O_SAMPLE_VALID) ? 1 : gap_ff + 1;
    seen_ff <= !I_RST && (seen_ff || O_SAMPLE_VALID);
  end
  one_wait_a:
    assert property (rq && O_AVM_WAITREQUEST |=> !O_AVM_WAITREQUEST)
    else $error("waitrequest held past one cycle");
  idle_wait_a:
    assert property (!rq |-> !O_AVM_WAITREQUEST)
    else $error("waitrequest high without request");
  byte_read_a:
    assert property (O_AVM_READDATA[31:8] == 24'h000000)
    else $error("read data above one byte");
  law_select_a:
    assert property (wt && I_AVM_ADDRESS == IDX_MODE1 |=>
      O_ALAW_SEL == $past(I_AVM_WRITEDATA[M1_ALAW]))
    else $error("law select not following mode write");
  loop_two_a:
    assert property (wt && I_AVM_ADDRESS == IDX_MODE3 |=>
      O_ANALOG_DISABLE == $past(I_AVM_WRITEDATA[M3_LOOP2]))
    else $error("loopback two not following mode write");
  loop_mute_a:
    assert property (O_ANALOG_DISABLE |-> O_INPUT_MUTE)
    else $error("inputs live during loopback two");
  preamp_cap_a:
    assert property (O_PREAMP_GAIN <= PREAMP_MAX)
    else $error("preamp gain out of range");
  valid_pulse_a:
    assert property (O_SAMPLE_VALID |=> !O_SAMPLE_VALID)
    else $error("sample pulse longer than one cycle");
  sample_rate_a:
    assert property (O_SAMPLE_VALID && seen_ff |-> gap_ff == SAMPLE_CYCLES)
    else $error("sample period wrong");
  tx_hold_a:
    assert property (!$stable(O_TX_SAMPLE) |-> O_SAMPLE_VALID)
    else $error("transmit sample changed mid period");
  cover property (wt && I_AVM_ADDRESS == IDX_MODE1);
  cover property (O_ANALOG_DISABLE && O_PREAMP_GAIN == PREAMP_MAX);
  cover property (O_SAMPLE_VALID && seen_ff);
endmodule
bind vpg_top vpg_chk #(.SAMPLE_CYCLES(SAMPLE_CYCLES)) vpg_chk_i (
  .I_REF_CLK(I_REF_CLK),
  .I_RST(I_RST),
  .I_AVM_ADDRESS(I_AVM_ADDRESS),
  .I_AVM_READ(I_AVM_READ),
  .I_AVM_WRITE(I_AVM_WRITE),
  .I_AVM_WRITEDATA(I_AVM_WRITEDATA),
  .I_AVM_BYTEENABLE(I_AVM_BYTEENABLE),
  .O_AVM_READDATA(O_AVM_READDATA),
  .O_AVM_WAITREQUEST(O_AVM_WAITREQUEST),
  .O_TX_SAMPLE(O_TX_SAMPLE),
  .O_SAMPLE_VALID(O_SAMPLE_VALID),
  .O_ALAW_SEL(O_ALAW_SEL),
  .O_ANALOG_DISABLE(O_ANALOG_DISABLE),
  .O_INPUT_MUTE(O_INPUT_MUTE),
  .O_PREAMP_GAIN(O_PREAMP_GAIN)
);

// ### testbench/vpg_host.sv
// Host processor model on the register bus
`timescale 1ns/10ps
module vpg_host
(
  input wire logic i_clk,
  input wire logic i_wait,
  input wire logic [31:0] i_rdata,
  output logic [7:0] o_addr,
  output logic o_rd,
  output logic o_wr,
  output logic [31:0] o_wdata,
  output logic [3:0] o_be
);
  initial
  begin
    o_addr = 8'h00;
    o_rd = 1'b0;
    o_wr = 1'b0;
    o_wdata = 32'h00000000;
    o_be = 4'h0;
  end
  // no mux loop writes; analog loop lives outside
  task automatic xfer(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q, output logic ok);
    int n;
    ok = 1'b0;
    q = 8'h00;
    @(posedge i_clk);
    o_addr <= a;
    o_wdata <= {24'h000000, d};
    o_be <= 4'hF;
    o_rd <= !w;
    o_wr <= w;
    for (n = 0; n < 40 && !ok; n++)
    begin
      @(posedge i_clk);
      if (i_wait === 1'b0)
      begin
        ok = 1'b1;
        q = i_rdata[7:0];
      end
    end
    o_rd <= 1'b0;
    o_wr <= 1'b0;
  endtask
endmodule

// ### testbench/tb_vpg_top.sv
// Self-checking bench for the voice-path block
`timescale 1ns/10ps
module tb_vpg_top;
  import vpg_pkg::*;
  localparam int SC = 8;
  localparam logic [15:0] ADC_V = 16'h0800;
  localparam logic [15:0] PCM_V = 16'h0123;
  logic clk;
  logic rst;
  logic [7:0] addr;
  logic avm_rd;
  logic avm_wr;
  logic [31:0] wdata;
  logic [3:0] be;
  logic [31:0] rdata;
  logic wreq;
  logic [15:0] adc;
  logic [15:0] pcm;
  logic [15:0] tx;
  logic [15:0] rx;
  logic valid;
  logic alaw;
  logic adis;
  logic mute;
  logic [2:0] pre;
  int err_total;
  int samples_checked;
  vpg_host vpg_host_i (.i_clk(clk), .i_wait(wreq), .i_rdata(rdata),
    .o_addr(addr), .o_rd(avm_rd), .o_wr(avm_wr), .o_wdata(wdata),
    .o_be(be));
  vpg_top #(.SAMPLE_CYCLES(SC)) vpg_top_i (.I_REF_CLK(clk), .I_RST(rst),
    .I_AVM_ADDRESS(addr), .I_AVM_READ(avm_rd), .I_AVM_WRITE(avm_wr),
    .I_AVM_WRITEDATA(wdata), .I_AVM_BYTEENABLE(be),
    .O_AVM_READDATA(rdata), .O_AVM_WAITREQUEST(wreq),
    .I_ADC_SAMPLE(adc), .I_RX_PCM(pcm), .O_TX_SAMPLE(tx),
    .O_RX_SAMPLE(rx), .O_SAMPLE_VALID(valid), .O_ALAW_SEL(alaw),
    .O_ANALOG_DISABLE(adis), .O_INPUT_MUTE(mute), .O_PREAMP_GAIN(pre));
  initial
  begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  task automatic finish_test();
    $display("comparisons %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      err_total++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a,
    input logic [7:0] d, output logic [7:0] q);
    logic ok;
    vpg_host_i.xfer(w, a, d, q, ok);
    if (!ok)
    begin
      err_total++;
      $display("BAD %0t bus access timed out", $time);
      finish_test();
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    check({8'h00, q}, {8'h00, exp});
  endtask
  task automatic wait_valid(input int n);
    int k;
    int c;
    c = 0;
    for (k = 0; k < 4 * SC * n && c < n; k++)
    begin
      @(posedge clk);
      #1;
      if (valid === 1'b1)
        c++;
    end
    if (c < n)
    begin
      err_total++;
      $display("BAD %0t no sample pulse", $time);
      finish_test();
    end
  endtask
  task automatic t_reset_regs();
    logic [7:0] idx [8];
    idx = '{IDX_MODE1, IDX_MODE2, IDX_MODE3, IDX_RINGA, IDX_RINGF,
      IDX_TONEF, IDX_TONEF, 8'h00};
    foreach (idx[i])
      rd(idx[i], 8'h00);
    $display("reset register test done");
  endtask
  task automatic t_defaults();
    @(posedge clk);
    adc <= ADC_V;
    pcm <= PCM_V;
    wait_valid(3);
    check(tx, ADC_V);
    check(rx, PCM_V + (ADC_V >>> 3));
    $display("default path test done");
  endtask
  task automatic t_mode_one();
    wr(IDX_MODE1, 8'h01);
    rd(IDX_MODE1, 8'h01);
    check({15'h0000, alaw}, 16'h0001);
    wr(IDX_MODE1, 8'h00);
    @(posedge clk);
    check({15'h0000, alaw}, 16'h0000);
    $display("mode one test done");
  endtask
  task automatic t_gain_mute();
    wr(IDX_TXGAIN, 8'h08);
    wr(IDX_TXGAIN, 8'h90);
    rd(IDX_TXGAIN, 8'h08);
    rd(IDX_TXGAIN, 8'h90);
    wr(IDX_MODE1, 8'h02);
    wait_valid(3);
    check(tx, 16'h0000);
    check(rx, PCM_V);
    wr(IDX_TXGAIN, 8'h00);
    wait_valid(3);
    check(tx, 16'h0000);
    wr(IDX_TXGAIN, 8'h90);
    wr(IDX_RXGAIN, 8'h08);
    wr(IDX_RXGAIN, 8'h90);
    wr(IDX_ERGAIN, 8'h08);
    wr(IDX_ERGAIN, 8'h00);
    wr(IDX_MODE1, 8'h0A);
    wait_valid(3);
    // Code 9000 scales by minus two; sidetone adds an eighth of it
    check(tx, 16'hF000);
    check(rx, 16'hFE00);
    $display("gain mute test done");
  endtask
  task automatic t_filter();
    wr(IDX_MODE1, 8'h00);
    for (int j = 0; j < 8; j++)
    begin
      wr(IDX_XFILT, 8'h08);
      wr(IDX_XFILT, 8'h90);
    end
    wait_valid(3);
    check(tx, ADC_V);
    wr(IDX_MODE1, 8'h10);
    wait_valid(3);
    // Every 9008 tap is minus one over eight equal samples
    check(tx, 16'hC000);
    check(rx, PCM_V - ADC_V);
    wr(IDX_MODE1, 8'h00);
    $display("filter test done");
  endtask
  task automatic t_loop_two();
    wr(IDX_STGAIN, 8'h08);
    wr(IDX_STGAIN, 8'h90);
    wr(IDX_MODE1, 8'h40);
    wr(IDX_MODE3, 8'h74);
    rd(IDX_MODE3, 8'h74);
    check({13'h0000, adis, mute, alaw}, 16'h0006);
    check({13'h0000, pre}, {13'h0000, PREAMP_MAX});
    wait_valid(3);
    check(tx, PCM_V);
    check(rx, PCM_V);
    wr(IDX_MODE1, 8'hC0);
    wait_valid(3);
    // Loop one gain 1+1/4+1/16+1/64 on the receive output
    check(tx, 16'h0182);
    wr(IDX_MODE3, 8'h00);
    @(posedge clk);
    check({13'h0000, adis, mute, alaw}, 16'h0000);
    $display("loopback two test done");
  endtask
  initial
  begin
    err_total = 0;
    samples_checked = 0;
    rst = 1'b1;
    adc = 16'h0000;
    pcm = 16'h0000;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_reset_regs();
    t_defaults();
    t_mode_one();
    t_gain_mute();
    t_filter();
    t_loop_two();
    finish_test();
  end
endmodule
